// >>> src/ipl_prio_regs.sv
// ipl_prio_regs: sfr priority-level store for eleven interrupt sources
//
// Contract
// [RULE_01] Legacy low register holds ext0..pca low bits at bits 0..6.
// [RULE_02] Newer low register holds can, adc, overrun, spi at bits 0..3.
// [RULE_03] Legacy high register pairs its bits 6..0 with the legacy low bits.
// [RULE_04] Level per source is {high bit, low bit}, 00 lowest, 11 highest.
// [RULE_05] Legacy registers clear bits 6..0 on reset; low one is bit-addressable.
// [RULE_06] Newer low register clears bits 3..0 on reset and is bit-addressable.
// [RULE_07] Software never sets reserved bits nor trusts their read value.
// [RULE_08] Newer high register holds can, adc, overrun, spi high bits, reset clear.
// [RULE_09] Equal levels are resolved by fixed poll order, overrun 10 and spi 11 last.
`timescale 1ns/1ps
module ipl_prio_regs
  import ipl_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // sfr byte access
  input  wire logic [7:0]            sfr_addr,
  input  wire logic                  sfr_wr,
  input  wire logic [7:0]            sfr_wdata,
  input  wire logic                  sfr_rd,
  output logic [7:0]                 sfr_rdata_q,
  output logic                       sfr_hit,
  // sfr single-bit access (bit-addressable registers only)
  input  wire logic                  bit_wr,
  input  wire logic [7:0]            bit_byte_addr,
  input  wire logic [2:0]            bit_sel,
  input  wire logic                  bit_wdata,
  // levels out
  output logic [2*IPL_NSRC-1:0]      src_level,
  // arbitration
  input  wire logic [IPL_NSRC-1:0]   src_pend,
  output logic                       win_valid_q,
  output logic [3:0]                 win_idx_q,
  output ipl_pkg::ipl_level_t        win_level_q
);
  logic [6:0] leg_lo_q;
  logic [6:0] leg_hi_q;
  logic [3:0] new_lo_q;
  logic [3:0] new_hi_q;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic byte_wr(input logic [7:0] a);
    byte_wr = sfr_wr && (sfr_addr == a);
  endfunction

  function automatic logic bit_hit(input logic [7:0] a);
    bit_hit = bit_wr && (bit_byte_addr == a);
  endfunction

  function automatic ipl_level_t level_pair(input logic hi, input logic lo);
    level_pair = {hi, lo};
  endfunction

  assign sfr_hit = (sfr_addr == IPL_ADDR_LEG_HI) || (sfr_addr == IPL_ADDR_LEG_LO)
                || (sfr_addr == IPL_ADDR_NEW_HI) || (sfr_addr == IPL_ADDR_NEW_LO);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // reserved bits are not stored, so a stray write to them is harmless
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      leg_lo_q <= IPL_LEG_RST; // [RULE_05]
    end else if (byte_wr(IPL_ADDR_LEG_LO)) begin
      leg_lo_q <= sfr_wdata[6:0]; // [RULE_01]
    end else if (bit_hit(IPL_ADDR_LEG_LO) && bit_sel != 3'd7) begin
      leg_lo_q[bit_sel] <= bit_wdata; // [RULE_05]
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      leg_hi_q <= IPL_LEG_RST; // [RULE_05]
    end else if (byte_wr(IPL_ADDR_LEG_HI)) begin
      leg_hi_q <= sfr_wdata[6:0]; // [RULE_03]
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      new_lo_q <= IPL_NEW_RST; // [RULE_06]
    end else if (byte_wr(IPL_ADDR_NEW_LO)) begin
      new_lo_q <= sfr_wdata[3:0]; // [RULE_02]
    end else if (bit_hit(IPL_ADDR_NEW_LO) && !bit_sel[2]) begin
      new_lo_q[bit_sel[1:0]] <= bit_wdata; // [RULE_06]
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      new_hi_q <= IPL_NEW_RST; // [RULE_08]
    end else if (byte_wr(IPL_ADDR_NEW_HI)) begin
      new_hi_q <= sfr_wdata[3:0]; // [RULE_08]
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // reserved bits read zero; software must not depend on it
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        IPL_ADDR_LEG_LO: sfr_rdata_q <= {1'b0, leg_lo_q};
        IPL_ADDR_LEG_HI: sfr_rdata_q <= {1'b0, leg_hi_q};
        IPL_ADDR_NEW_LO: sfr_rdata_q <= {4'h0, new_lo_q};
        IPL_ADDR_NEW_HI: sfr_rdata_q <= {4'h0, new_hi_q};
        default:         sfr_rdata_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // levels
  // ----------------------------------------
  always_comb begin
    for (int k = 0; k < IPL_NLEG; k++) begin
      src_level[2*k +: 2] = level_pair(leg_hi_q[k], leg_lo_q[k]); // [RULE_04]
    end
    for (int k = 0; k < IPL_NNEW; k++) begin
      src_level[2*(IPL_NLEG+k) +: 2] = level_pair(new_hi_q[k], new_lo_q[k]); // [RULE_04]
    end
  end

  ipl_arbiter #(
    .N (IPL_NSRC)
  ) u_arb (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .pend        (src_pend),
    .levels      (src_level),
    .win_valid_q (win_valid_q),
    .win_idx_q   (win_idx_q),
    .win_level_q (win_level_q)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // strobes spelled out: inside a property the decode functions read post-edge values
  leg_lo_write_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_01]
    sfr_wr && sfr_addr == IPL_ADDR_LEG_LO |=> leg_lo_q == $past(sfr_wdata[6:0]))
    else $error("legacy low write lost");
  new_lo_write_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_02]
    sfr_wr && sfr_addr == IPL_ADDR_NEW_LO |=> new_lo_q == $past(sfr_wdata[3:0]))
    else $error("newer low write lost");
  leg_hi_write_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_03]
    sfr_wr && sfr_addr == IPL_ADDR_LEG_HI
    |=> src_level[2*IPL_SRC_PCA+1] == $past(sfr_wdata[6]))
    else $error("pca high bit mismatch");
  level_form_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_04]
    src_level[2*IPL_SRC_SPI +: 2] == {new_hi_q[3], new_lo_q[3]})
    else $error("spi level formed wrongly");
  leg_reset_a: assert property (@(posedge mclk) // [RULE_05]
    !reset_n |=> leg_lo_q == IPL_LEG_RST && leg_hi_q == IPL_LEG_RST)
    else $error("legacy not cleared");
  new_reset_a: assert property (@(posedge mclk) // [RULE_06]
    !reset_n |=> new_lo_q == IPL_NEW_RST && sfr_rdata_q == 8'h00)
    else $error("newer low not cleared");
  new_hi_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_08]
    sfr_rd && sfr_addr == IPL_ADDR_NEW_HI |=> sfr_rdata_q == {4'h0, $past(new_hi_q)})
    else $error("newer high read wrong");
  tie_order_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_09]
    src_pend == 11'b110_0000_0000 && src_level[21:18] == 4'b0000
    |=> win_idx_q == 4'(IPL_SRC_OVR))
    else $error("tie order wrong");
  leg_lo_bit_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_05]
    bit_wr && !sfr_wr && bit_byte_addr == IPL_ADDR_LEG_LO && bit_sel != 3'd7
    |=> leg_lo_q[$past(bit_sel)] == $past(bit_wdata))
    else $error("legacy low bit write lost");
  new_lo_bit_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_06]
    bit_wr && !sfr_wr && bit_byte_addr == IPL_ADDR_NEW_LO && !bit_sel[2]
    |=> new_lo_q[$past(bit_sel[1:0])] == $past(bit_wdata))
    else $error("newer low bit write lost");
  new_hi_write_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_08]
    sfr_wr && sfr_addr == IPL_ADDR_NEW_HI |=> new_hi_q == $past(sfr_wdata[3:0]))
    else $error("newer high write lost");
  leg_lo_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_01]
    !sfr_wr && !bit_wr |=> $stable(leg_lo_q))
    else $error("legacy low changed unasked");
  new_lo_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_02]
    !sfr_wr && !bit_wr |=> $stable(new_lo_q))
    else $error("newer low changed unasked");
  leg_hi_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_03]
    !sfr_wr |=> $stable(leg_hi_q))
    else $error("legacy high changed unasked");
  new_hi_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_08]
    !sfr_wr |=> $stable(new_hi_q))
    else $error("newer high changed unasked");
  leg_lo_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_01]
    sfr_rd && sfr_addr == IPL_ADDR_LEG_LO |=> sfr_rdata_q == {1'b0, $past(leg_lo_q)})
    else $error("legacy low read wrong");
  leg_hi_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_03]
    sfr_rd && sfr_addr == IPL_ADDR_LEG_HI |=> sfr_rdata_q == {1'b0, $past(leg_hi_q)})
    else $error("legacy high read wrong");
  new_lo_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_02]
    sfr_rd && sfr_addr == IPL_ADDR_NEW_LO |=> sfr_rdata_q == {4'h0, $past(new_lo_q)})
    else $error("newer low read wrong");
  hit_high_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_08]
    sfr_addr == IPL_ADDR_LEG_HI || sfr_addr == IPL_ADDR_NEW_HI |-> sfr_hit)
    else $error("high register not decoded");
  hit_low_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_02]
    sfr_addr == IPL_ADDR_LEG_LO || sfr_addr == IPL_ADDR_NEW_LO |-> sfr_hit)
    else $error("low register not decoded");

  // ----------------------------------------
  // arbitration checks
  // ----------------------------------------
  win_level_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_04]
    src_pend[IPL_SRC_SPI] |=> win_level_q >= $past(src_level[2*IPL_SRC_SPI +: 2]))
    else $error("winner below a pending level");
  win_valid_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_09]
    src_pend != '0 |=> win_valid_q)
    else $error("pending source not seen");
  win_idle_a: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_09]
    src_pend == '0 |=> !win_valid_q && win_idx_q == IPL_NONE)
    else $error("idle winner wrong");
endmodule

// >>> shared/ipl_pkg.sv
// ipl_pkg: addresses, field layout, reset values of the interrupt priority store
package ipl_pkg;
  localparam int          IPL_AW          = 8;
  localparam int          IPL_DW          = 8;
  localparam int          IPL_NSRC        = 11;
  localparam int          IPL_NLEG        = 7;
  localparam int          IPL_NNEW        = 4;
  // sfr addresses
  localparam logic [7:0]  IPL_ADDR_LEG_HI = 8'hb7;
  localparam logic [7:0]  IPL_ADDR_LEG_LO = 8'hb8;
  localparam logic [7:0]  IPL_ADDR_NEW_HI = 8'hf7;
  localparam logic [7:0]  IPL_ADDR_NEW_LO = 8'hf8;
  // reset values of implemented bits
  localparam logic [6:0]  IPL_LEG_RST     = 7'h00;
  localparam logic [3:0]  IPL_NEW_RST     = 4'h0;
  // source index = polling rank - 1; legacy bits 0..6, newer bits 0..3 from 7
  localparam int          IPL_SRC_EXT0    = 0;
  localparam int          IPL_SRC_TMR0    = 1;
  localparam int          IPL_SRC_EXT1    = 2;
  localparam int          IPL_SRC_TMR1    = 3;
  localparam int          IPL_SRC_SERIAL  = 4;
  localparam int          IPL_SRC_TMR2    = 5;
  localparam int          IPL_SRC_PCA     = 6;
  localparam int          IPL_SRC_CAN     = 7;
  localparam int          IPL_SRC_ADC     = 8;
  localparam int          IPL_SRC_OVR     = 9;
  localparam int          IPL_SRC_SPI     = 10;
  localparam logic [3:0]  IPL_NONE        = 4'hf;
  typedef logic [1:0] ipl_level_t;
endpackage

// >>> src/ipl_arbiter.sv
// ipl_arbiter: highest level, then lowest poll index among pending sources
`timescale 1ns/1ps
module ipl_arbiter
  import ipl_pkg::*;
#(
  parameter int N = 11
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                reset_n,
  // sources
  input  wire logic [N-1:0]        pend,
  input  wire logic [2*N-1:0]      levels,
  // winner
  output logic                     win_valid_q,
  output logic [3:0]               win_idx_q,
  output ipl_pkg::ipl_level_t      win_level_q
);
  logic       v_d;
  logic [3:0] i_d;
  ipl_level_t l_d;

  if (N > 15) begin : g_chk
    $error("ipl_arbiter: N too large for 4-bit index");
  end

  // strictly greater only: equal levels keep the earlier poll index
  always_comb begin
    v_d = 1'b0;
    i_d = IPL_NONE;
    l_d = 2'b00;
    for (int k = 0; k < N; k++) begin
      if (pend[k] && (!v_d || levels[2*k +: 2] > l_d)) begin // [RULE_09]
        v_d = 1'b1;
        i_d = 4'(k);
        l_d = levels[2*k +: 2];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      win_valid_q <= 1'b0;
      win_idx_q   <= IPL_NONE;
      win_level_q <= 2'b00;
    end else begin
      win_valid_q <= v_d;
      win_idx_q   <= i_d;
      win_level_q <= l_d;
    end
  end
endmodule

// >>> dv/tb_top.sv
// tb_top: self-checking bench for the interrupt priority-level store
`timescale 1ns/1ps
module tb_top;
  import ipl_pkg::*;
  logic                  mclk, reset_n, sfr_wr, sfr_rd, bit_wr, bit_wdata;
  logic [7:0]            sfr_addr, sfr_wdata, bit_byte_addr, sfr_rdata_q, v;
  logic [2:0]            bit_sel;
  logic [IPL_NSRC-1:0]   src_pend;
  logic [2*IPL_NSRC-1:0] src_level, lv;
  logic                  sfr_hit, win_valid_q;
  logic [3:0]            win_idx_q;
  ipl_level_t            win_level_q;
  int                    num_errors, comparisons;

  ipl_prio_regs dut (.mclk, .reset_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
    .sfr_rdata_q, .sfr_hit, .bit_wr, .bit_byte_addr, .bit_sel, .bit_wdata,
    .src_level, .src_pend, .win_valid_q, .win_idx_q, .win_level_q);

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr <= a; sfr_wdata <= d; sfr_wr <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
  endtask
  task automatic bw(input logic [7:0] a, input logic [2:0] s, input logic d);
    @(posedge mclk);
    bit_byte_addr <= a; bit_sel <= s; bit_wdata <= d; bit_wr <= 1'b1;
    @(posedge mclk);
    bit_wr <= 1'b0;
  endtask
  // read data lands one edge after the strobe; sampled mid-cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string m);
    @(posedge mclk);
    sfr_addr <= a; sfr_rd <= 1'b1;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    @(negedge mclk);
    check(sfr_rdata_q, exp, m);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(IPL_ADDR_LEG_LO, 8'h00, "leg lo rst");
    rd(IPL_ADDR_LEG_HI, 8'h00, "leg hi rst");
    rd(IPL_ADDR_NEW_LO, 8'h00, "new lo rst");
    rd(IPL_ADDR_NEW_HI, 8'h00, "new hi rst");
    check(sfr_hit, 1'b1, "hit f7");
    check(win_idx_q, IPL_NONE, "idle winner");
  endtask
  // all-ones field values (7f, 0f) read back whole; reserved bits are written as zero here
  task automatic t_bytes();
    wr(IPL_ADDR_LEG_LO, 8'h7f); rd(IPL_ADDR_LEG_LO, 8'h7f, "leg lo full");
    wr(IPL_ADDR_NEW_LO, 8'h0f); rd(IPL_ADDR_NEW_LO, 8'h0f, "new lo full");
    wr(IPL_ADDR_LEG_LO, 8'h55); wr(IPL_ADDR_LEG_HI, 8'h2a);
    wr(IPL_ADDR_NEW_LO, 8'h05); wr(IPL_ADDR_NEW_HI, 8'h0a);
    for (int k = 0; k < IPL_NSRC; k++) begin
      lv[2*k]   = (k < IPL_NLEG) ? k % 2 == 0 : (k - IPL_NLEG) % 2 == 0;
      lv[2*k+1] = !lv[2*k];
    end
    @(negedge mclk);
    check(src_level, lv, "levels");
    rd(IPL_ADDR_LEG_HI, 8'h2a, "leg hi");
    rd(IPL_ADDR_NEW_HI, 8'h0a, "new hi");
    wr(8'hb9, 8'hff); rd(8'hb9, 8'h00, "unmapped");
    check(sfr_hit, 1'b0, "hit b9");
  endtask
  task automatic t_bits();
    wr(IPL_ADDR_LEG_LO, 8'h00); wr(IPL_ADDR_NEW_LO, 8'h00);
    bw(IPL_ADDR_LEG_LO, 3'd6, 1'b1); bw(IPL_ADDR_LEG_HI, 3'd0, 1'b1);
    rd(IPL_ADDR_LEG_LO, 8'h40, "leg lo bit");
    rd(IPL_ADDR_LEG_HI, 8'h2a, "leg hi no bit");
    bw(IPL_ADDR_NEW_LO, 3'd3, 1'b1); bw(IPL_ADDR_NEW_HI, 3'd0, 1'b1);
    rd(IPL_ADDR_NEW_LO, 8'h08, "new lo bit");
    rd(IPL_ADDR_NEW_HI, 8'h0a, "new hi no bit");
    bw(IPL_ADDR_NEW_LO, 3'd3, 1'b0);
    rd(IPL_ADDR_NEW_LO, 8'h00, "new lo clr");
  endtask
  // equal levels fall back to poll order; a higher level beats it
  task automatic t_arb();
    wr(IPL_ADDR_LEG_LO, 8'h00); wr(IPL_ADDR_LEG_HI, 8'h00); wr(IPL_ADDR_NEW_HI, 8'h00);
    @(posedge mclk);
    src_pend <= 11'h600;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check(win_idx_q, IPL_SRC_OVR, "tie");
    wr(IPL_ADDR_NEW_HI, 8'h08);
    @(posedge mclk);
    @(negedge mclk);
    check({win_valid_q, win_level_q, win_idx_q}, {3'b110, 4'(IPL_SRC_SPI)}, "spi");
    @(posedge mclk);
    src_pend <= '0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check({win_valid_q, win_idx_q}, {1'b0, IPL_NONE}, "none");
  endtask

  // ---------------------------------------------------------------
  // run
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
  initial begin
    {reset_n, sfr_wr, sfr_rd, bit_wr, bit_wdata, bit_sel} = '0;
    {sfr_addr, sfr_wdata, bit_byte_addr, src_pend} = '0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_bytes();
    t_bits();
    t_arb();
    test_done();
  end
endmodule
